// >>> logic/mri_params.svh
// Register offsets, field positions and reset values of the receive irq block
`ifndef MRI_PARAMS_SVH
`define MRI_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define MRI_OFF_ENABLE 8'h00
`define MRI_OFF_STATUS 8'h04
`define MRI_OFF_CLEAR 8'h08

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define MRI_EN_W 7
`define MRI_SRC_W 6
`define MRI_BIT_MASTER 0
`define MRI_BIT_CHECKSUM 1
`define MRI_BIT_OVERFLOW 2
`define MRI_BIT_LONG 3
`define MRI_BIT_GOOD 4
`define MRI_BIT_ALIGN 5
`define MRI_BIT_RUNT 6
`define MRI_WORD_LSB 2
`define MRI_LANE0 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MRI_ENABLE_RST 7'h00
`define MRI_FLAGS_RST 6'h00
`define MRI_DATA_RST 32'h0000_0000

`endif

// >>> logic/mri_pkg.sv
// Types shared by the receive interrupt enable block
`default_nettype none
package mri_pkg;

    // ----------------------------------------------------------------
    // Receive status events, one pulse per source
    // ----------------------------------------------------------------
    typedef struct packed {
        logic runt_frame_flag;
        logic alignment_error_flag;
        logic good_frame_flag;
        logic long_frame_flag;
        logic fifo_overflow_flag;
        logic checksum_error_flag;
    } mri_rx_events_t;

    // ----------------------------------------------------------------
    // Whole state of the block
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [6:0] enable;
        logic [6:1] flags;
        logic irq;
        logic ack;
        logic [31:0] rdata;
    } mri_state_t;

endpackage
`default_nettype wire

// >>> logic/mri_top.sv
// Receive interrupt enable, status flags and Wishbone slave of the MAC
//
// Behaviour
// - Enable bit 6 gates runt frame flag
// - Enable bit 5 gates alignment error flag
// - Enable bit 4 gates good frame flag
// - Enable bit 3 gates long frame flag
// - Enable bit 2 gates fifo overflow flag
// - Enable bit 1 gates checksum error flag
// - Second gate is receive master, transmit optional; the code puts transmit in each source gate, so it masks the summary too
// - Master enable and summary drive the interrupt
// - Master off means no receive interrupt
// - Writing one clears a flag, zero keeps
// - Summary flag is OR of enabled flags
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mri_params.svh"

module mri_top #(
    parameter int ADDR_W = 8,
    parameter bit USE_TX_MASTER = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire mri_pkg::mri_rx_events_t rx_events_i,
    input wire logic transmit_master_irq_enable_i,
    output logic receive_summary_flag_o,
    output logic rx_irq_o
);
    import mri_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie between 4 and 32");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    mri_state_t st_r;
    mri_state_t st_nxt;

    logic req_w;
    logic wr_w;
    logic hit_enable_w;
    logic hit_status_w;
    logic hit_clear_w;
    logic tx_ok_w;
    logic [`MRI_SRC_W-1:0] events_w;
    wire logic [`MRI_SRC_W-1:0] pending_w;
    logic summary_w;
    logic [7:0] word_adr_w;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Only the word index matters; byte offsets within a word alias
    assign word_adr_w = 8'({wb_adr_i[ADDR_W-1:`MRI_WORD_LSB], 2'h0});
    assign hit_enable_w = (word_adr_w == `MRI_OFF_ENABLE);
    assign hit_status_w = (word_adr_w == `MRI_OFF_STATUS);
    assign hit_clear_w = (word_adr_w == `MRI_OFF_CLEAR);
    assign req_w = wb_cyc_i && wb_stb_i;
    // Write lands on the edge that samples ack, as the master expects
    assign wr_w = req_w && wb_we_i && st_r.ack && wb_sel_i[`MRI_LANE0];

    // ----------------------------------------------------------------
    // Interrupt gating
    // ----------------------------------------------------------------
    assign events_w = rx_events_i;
    // Transmit master only joins the gate when the option is built in
    assign tx_ok_w = !USE_TX_MASTER || transmit_master_irq_enable_i;

    // One gate per source; vector bit g serves status bit g+1
    for (genvar g = 0; g < `MRI_SRC_W; g++) begin : g_src
        mri_src_gate u_gate (
            .flag_i(st_r.flags[g+1]),
            .enable_i(st_r.enable[g+1]),
            .tx_ok_i(tx_ok_w),
            .pend_o(pending_w[g])
        );
    end

    assign summary_w = |pending_w;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = req_w && !st_r.ack;

        if (wr_w && hit_enable_w) begin
            st_nxt.enable = wb_dat_i[`MRI_EN_W-1:0];
        end

        // Clear first, then set, so a same-cycle event is kept
        if (wr_w && (hit_status_w || hit_clear_w)) begin
            st_nxt.flags = st_r.flags & ~wb_dat_i[`MRI_SRC_W:1];
        end
        st_nxt.flags = st_nxt.flags | events_w;

        // Read data is captured on the request cycle, shown with ack
        if (req_w && !st_r.ack) begin
            st_nxt.rdata = `MRI_DATA_RST;
            if (hit_enable_w) begin
                st_nxt.rdata[`MRI_EN_W-1:0] = st_r.enable;
            end else if (hit_status_w) begin
                st_nxt.rdata[`MRI_SRC_W:1] = st_r.flags;
                st_nxt.rdata[`MRI_BIT_MASTER] = summary_w;
            end
        end

        // Master clear forces the level low one clock later
        st_nxt.irq = summary_w;
        st_nxt.irq = st_nxt.irq && st_r.enable[`MRI_BIT_MASTER];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.enable <= `MRI_ENABLE_RST;
            st_r.flags <= `MRI_FLAGS_RST;
            st_r.irq <= 1'b0;
            st_r.ack <= 1'b0;
            st_r.rdata <= `MRI_DATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_dat_o = st_r.rdata;
    assign wb_ack_o = st_r.ack;
    assign receive_summary_flag_o = summary_w;
    // Master bit alone decides whether the summary reaches the CPU
    assign rx_irq_o = st_r.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic master_w;
    assign master_w = st_r.enable[`MRI_BIT_MASTER];
    logic [`MRI_EN_W-1:0] enable_w;
    logic [`MRI_EN_W-1:0] wdat_en_w;
    assign enable_w = st_r.enable;
    assign wdat_en_w = wb_dat_i[`MRI_EN_W-1:0];

    sequence s_bus_req;
        req_w && !wb_ack_o;
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence s_clear_write(int b);
        wr_w && hit_clear_w && wb_dat_i[b] && !events_w[b-1];
    endsequence

    sequence s_src_live(int b);
        st_r.flags[b] && st_r.enable[b] && tx_ok_w;
    endsequence

    sequence s_status_write(int b);
        wr_w && hit_status_w && wb_dat_i[b] && !events_w[b-1];
    endsequence

    sequence s_read_of(hit);
        s_bus_req ##0 (!wb_we_i && hit);
    endsequence

    a_bus_ack_pulse: assert property (
        s_bus_req |=> s_ack_pulse
    ) else $error("Ack is not a single pulse one cycle after request");

    a_runt_gate: assert property (
        st_r.flags[`MRI_BIT_RUNT] && st_r.enable[`MRI_BIT_RUNT] &&
        master_w && tx_ok_w |=> rx_irq_o
    ) else $error("Enabled runt flag did not raise the interrupt");

    a_align_mask: assert property (
        (st_r.enable[6:1] == 6'h10) && tx_ok_w
        |-> (summary_w == st_r.flags[`MRI_BIT_ALIGN])
    ) else $error("Alignment flag gating wrong");

    a_good_gate: assert property (
        !st_r.enable[`MRI_BIT_GOOD] |-> !pending_w[`MRI_BIT_GOOD-1]
    ) else $error("Masked good frame flag reached the summary");

    a_long_gate: assert property (
        pending_w[`MRI_BIT_LONG-1] && master_w |=> rx_irq_o
    ) else $error("Enabled long frame flag did not raise the interrupt");

    a_overflow_gate: assert property (
        $rose(pending_w[`MRI_BIT_OVERFLOW-1]) |->
        st_r.enable[`MRI_BIT_OVERFLOW] && st_r.flags[`MRI_BIT_OVERFLOW]
    ) else $error("Overflow flag passed without its enable");

    a_crc_gate: assert property (
        st_r.flags[`MRI_BIT_CHECKSUM] && st_r.enable[`MRI_BIT_CHECKSUM] &&
        tx_ok_w |-> summary_w
    ) else $error("Enabled checksum flag missing from summary");

    a_tx_master: assert property (
        USE_TX_MASTER && !transmit_master_irq_enable_i |-> !summary_w
    ) else $error("Summary set while transmit master enable is off");

    a_master_on: assert property (
        summary_w && master_w ##1 summary_w && master_w |-> rx_irq_o
    ) else $error("Interrupt low while summary and master are set");

    a_master_off: assert property (
        !master_w [*2] |-> !rx_irq_o
    ) else $error("Interrupt raised with the master enable clear");

    a_clear_flag: assert property (
        s_clear_write(`MRI_BIT_GOOD) |=> !st_r.flags[`MRI_BIT_GOOD]
    ) else $error("Write of one did not clear the good frame flag");

    a_event_sticky: assert property (
        events_w[`MRI_BIT_RUNT-1] |=> st_r.flags[`MRI_BIT_RUNT] [*2]
        or (st_r.flags[`MRI_BIT_RUNT] ##1 $past(wr_w))
    ) else $error("Runt event lost or flag not sticky");

    a_summary_read: assert property (
        s_bus_req ##0 (!wb_we_i && hit_status_w) |=>
        wb_dat_o[`MRI_BIT_MASTER] == $past(summary_w)
    ) else $error("Status read shows wrong summary bit");

    a_irq_level: assert property (
        rx_irq_o == $past(summary_w && master_w)
    ) else $error("Interrupt not equal to last cycle summary AND master");

    a_runt_mask: assert property (
        !st_r.enable[`MRI_BIT_RUNT] |-> !pending_w[`MRI_BIT_RUNT-1]
    ) else $error("Masked runt flag reached the summary");

    a_align_gate: assert property (
        s_src_live(`MRI_BIT_ALIGN) ##0 master_w |=> rx_irq_o
    ) else $error("Enabled alignment flag did not raise the interrupt");

    a_good_raise: assert property (
        s_src_live(`MRI_BIT_GOOD) ##0 master_w |=> rx_irq_o
    ) else $error("Enabled good frame flag did not raise the interrupt");

    a_long_mask: assert property (
        !st_r.enable[`MRI_BIT_LONG] |-> !pending_w[`MRI_BIT_LONG-1]
    ) else $error("Masked long frame flag reached the summary");

    a_overflow_raise: assert property (
        s_src_live(`MRI_BIT_OVERFLOW) ##0 master_w |=> rx_irq_o
    ) else $error("Enabled overflow flag did not raise the interrupt");

    a_crc_mask: assert property (
        !st_r.enable[`MRI_BIT_CHECKSUM] |-> !pending_w[`MRI_BIT_CHECKSUM-1]
    ) else $error("Masked checksum flag reached the summary");

    a_summary_need: assert property (
        !summary_w |=> !rx_irq_o
    ) else $error("Interrupt raised without the summary flag");

    a_master_gate: assert property (
        !master_w |=> !rx_irq_o
    ) else $error("Interrupt raised after the master enable was clear");

    a_clear_runt: assert property (
        s_clear_write(`MRI_BIT_RUNT) |=> !st_r.flags[`MRI_BIT_RUNT]
    ) else $error("Write of one did not clear the runt flag");

    a_status_clear: assert property (
        s_status_write(`MRI_BIT_CHECKSUM) |=>
        !st_r.flags[`MRI_BIT_CHECKSUM]
    ) else $error("Status write of one did not clear the checksum flag");

    a_zero_keeps: assert property (
        wr_w && (hit_clear_w || hit_status_w) &&
        !wb_dat_i[`MRI_BIT_RUNT] && st_r.flags[`MRI_BIT_RUNT]
        |=> st_r.flags[`MRI_BIT_RUNT]
    ) else $error("Write of zero cleared the runt flag");

    a_set_wins: assert property (
        events_w[`MRI_BIT_OVERFLOW-1] |=> st_r.flags[`MRI_BIT_OVERFLOW]
    ) else $error("Overflow event did not set its flag");

    a_flag_hold: assert property (
        st_r.flags[`MRI_BIT_GOOD] && !wr_w |=> st_r.flags[`MRI_BIT_GOOD]
    ) else $error("Good frame flag dropped without a clear");

    a_summary_idle: assert property (
        (st_r.flags == `MRI_FLAGS_RST) |-> !summary_w
    ) else $error("Summary set with no flag pending");

    a_irq_rise: assert property (
        $rose(rx_irq_o) |-> $past(summary_w) && $past(master_w)
    ) else $error("Interrupt rose without summary and master");

    a_ack_idle: assert property (
        !req_w |=> !wb_ack_o
    ) else $error("Ack given without a request");

    a_enable_write: assert property (
        wr_w && hit_enable_w |=> enable_w == $past(wdat_en_w)
    ) else $error("Enable write did not land");

    a_lane_guard: assert property (
        req_w && wb_we_i && !wb_sel_i[`MRI_LANE0] |=> $stable(enable_w)
    ) else $error("Write without byte lane zero changed the enables");

    a_enable_read: assert property (
        s_read_of(hit_enable_w) |=>
        wb_dat_o[`MRI_EN_W-1:0] == $past(enable_w)
    ) else $error("Enable read shows wrong value");

    a_clear_read: assert property (
        s_read_of(hit_clear_w) |=> wb_dat_o == `MRI_DATA_RST
    ) else $error("Clear register read not zero");

endmodule

// ----------------------------------------------------------------
// Per-source gate
// ----------------------------------------------------------------
module mri_src_gate (
    input wire logic flag_i,
    input wire logic enable_i,
    input wire logic tx_ok_i,
    output logic pend_o
);
    // A set flag counts only while its own enable is on
    assign pend_o = flag_i && enable_i && tx_ok_i;
endmodule
`default_nettype wire

// >>> verification/mri_evt_src.sv
// Receive status event source model for the interrupt bench
`timescale 1ns/1ps
`default_nettype none

module mri_evt_src (
    input wire logic clk_i,
    input wire logic [5:0] fire_i,
    output mri_pkg::mri_rx_events_t events_o
);
    import mri_pkg::*;

    // Registered so each request is a clean one-cycle event pulse
    always_ff @(posedge clk_i) begin
        events_o <= mri_rx_events_t'(fire_i);
    end
endmodule
`default_nettype wire

// >>> verification/mri_tb.sv
// Self-checking bench of the receive interrupt enable block
`timescale 1ns/1ps
`default_nettype none

module tb;
    import mri_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, txm = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [3:0] lanes = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic wb_ack_o, sum_o, rx_irq_o;
    logic [5:0] fire = 6'h00;
    mri_rx_events_t ev;
    int fail_count = 0, checked = 0;

    always #20 clk_i = ~clk_i;

    mri_evt_src src (.clk_i(clk_i), .fire_i(fire), .events_o(ev));
    mri_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wb_ack_o),
        .rx_events_i(ev), .transmit_master_irq_enable_i(txm),
        .receive_summary_flag_o(sum_o), .rx_irq_o(rx_irq_o));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= lanes;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            end_sim();
        end
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    // Looks one edge on so the registered interrupt has settled
    task automatic look(input logic s, input logic i);
        @(posedge clk_i);
        chk({30'h0, sum_o, rx_irq_o}, {30'h0, s, i});
    endtask

    task automatic pulse(input logic [5:0] v);
        fire <= v;
        @(posedge clk_i);
        fire <= 6'h00;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h10, 32'h0);
        wb(1'b1, 8'h10, 32'hffff_ffff, q);
        lanes = 4'he;
        wb(1'b1, 8'h00, 32'hffff_ffff, q);
        lanes = 4'hf;
        rd_chk(8'h00, 32'h0);
        wb(1'b1, 8'h00, 32'hffff_ffff, q);
        rd_chk(8'h00, 32'h0000_007f);
        rd_chk(8'h08, 32'h0);
        wb(1'b1, 8'h00, 32'h0, q);
        $display("regs test done");
    endtask

    // Each source masked, then enabled, then cleared by writing one
    task automatic t_gate;
        logic [6:0] b;
        for (int k = 1; k <= 6; k++) begin
            b = 7'h01 << k;
            wb(1'b1, 8'h00, {25'h0, 7'h7f ^ b}, q);
            pulse(b[6:1]);
            look(1'b0, 1'b0);
            rd_chk(8'h04, {25'h0, b});
            wb(1'b1, 8'h00, {25'h0, b | 7'h01}, q);
            look(1'b1, 1'b1);
            wb(1'b1, 8'h08, {25'h0, b}, q);
            look(1'b0, 1'b0);
        end
        wb(1'b1, 8'h00, 32'h0, q);
        $display("gate test done");
    endtask

    // Master enable off holds the interrupt low with all sources live
    task automatic t_master;
        wb(1'b1, 8'h00, 32'h0000_007e, q);
        pulse(6'h3f);
        look(1'b1, 1'b0);
        wb(1'b1, 8'h04, 32'h0, q);
        rd_chk(8'h04, 32'h0000_007f);
        wb(1'b1, 8'h00, 32'h0000_007f, q);
        look(1'b1, 1'b1);
        txm <= 1'b1;
        look(1'b1, 1'b1);
        txm <= 1'b0;
        wb(1'b1, 8'h04, 32'h0000_007e, q);
        rd_chk(8'h04, 32'h0);
        look(1'b0, 1'b0);
        $display("master test done");
    endtask

    // Reset in mid-run drops enables, flags and the interrupt
    task automatic t_reset;
        wb(1'b1, 8'h00, 32'h0000_007f, q);
        pulse(6'h01);
        look(1'b1, 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        look(1'b0, 1'b0);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        $display("reset test done");
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_gate();
        t_master();
        t_reset();
        end_sim();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #100us;
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
